// ### hw/rtcpc_pkg.sv
// Package with offsets, field positions, reset values and types of the battery-backed clock block
package rtcpc_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int TRIM_W = 16;
  localparam int HF_DIV_W = 7;
  localparam int SEC_IDX_W = 6;
  localparam int MEM_IDX_W = 6;
  localparam int EV_W = 4;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_COUNT = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_MATCH0 = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_MATCH1 = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_LOAD = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_MASK = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_RAW = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_MSKD = 12'h01c;
  localparam logic [ADDR_W-1:0] OFS_CLEAR = 12'h020;
  localparam logic [ADDR_W-1:0] OFS_TRIM = 12'h024;
  localparam logic [ADDR_W-1:0] OFS_MEM_LO = 12'h030;
  localparam logic [ADDR_W-1:0] OFS_MEM_HI = 12'h12c;
  // Reset values and divider end counts
  localparam logic [DATA_W-1:0] RST_MATCH = 32'hffffffff;
  localparam logic [DATA_W-1:0] RST_LOAD = 32'hffffffff;
  localparam logic [DATA_W-1:0] RST_COUNT = 32'h00000000;
  localparam logic [TRIM_W-1:0] TRIM_NOMINAL = 16'h7fff;
  localparam logic [HF_DIV_W-1:0] HF_DIV_LAST = 7'h7f;
  localparam logic [SEC_IDX_W-1:0] SEC_IDX_LAST = 6'h3f;
  // Control register bit positions; bit 31 reads as write-complete
  localparam int CTL_CNT_EN = 0;
  localparam int CTL_SLEEP_REQ = 1;
  localparam int CTL_CLK_SEL = 2;
  localparam int CTL_MATCH_RES = 3;
  localparam int CTL_PIN_RES = 4;
  localparam int CTL_LBAT_EN = 5;
  localparam int CTL_CLK_EN = 6;
  localparam int CTL_ABORT = 7;
  localparam int CTL_DONE = 31;
  // Event bit positions in raw, masked, mask and clear views
  localparam int EV_MATCH0 = 0;
  localparam int EV_MATCH1 = 1;
  localparam int EV_LOW_BATTERY_FLAG = 2;
  localparam int EV_WAKE = 3;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic abort_on_low_battery;
    logic clk_en;
    logic low_battery_detect_en;
    logic pin_resume_enable;
    logic match_resume_enable;
    logic clk_sel;
    logic counter_enable;
  } rtcpc_ctl_type;

  typedef enum logic {
    PWR_ON = 1'b0,
    PWR_SLEEP = 1'b1
  } rtcpc_pwr_type;
endpackage : rtcpc_pkg

// ### hw/rtcpc_top.sv
// Battery-backed seconds counter, retained memory and regulator power control with AXI4-Lite registers
// How it works
// RQ1 - Low-battery flag sets while detection enabled and battery sensed low
// RQ2 - With abort also enabled, low battery refuses a sleep request
// RQ3 - Battery level is ignored while in the sleep state
// RQ4 - 32-bit seconds counter steps by one each second
// RQ5 - Predivider counts reference ticks down to make a one-second pulse
// RQ6 - Trim value sets divide count one second in 64, nominal otherwise
// RQ7 - Larger trim lengthens that second, smaller trim shortens it
// RQ8 - Two 32-bit match values compared; match resumes or raises an event
// RQ9 - Counter advances only while enabled, powered or asleep
// RQ10 - Load register write replaces the counter at once, at any time
// RQ11 - 64 retained 32-bit words, readable and writable
// RQ12 - Sleep asserts active-low regulator enable; resume releases it
// RQ13 - Setting the sleep request bit starts the sleep sequence
// RQ14 - Software enables a resume source before requesting sleep
// RQ15 - Pin resume and match resume each have an enable; both allowed
// RQ16 - After resume, raw status keeps the cause
// RQ17 - Three event sources: resume pin, counter match, low battery
// RQ18 - Enabled events ORed onto one interrupt line
// RQ19 - Raw view shows all pending events, masked view only unmasked ones
// RQ20 - Only masked-in events drive the interrupt
// RQ21 - Writing one to a clear bit clears that event only
// RQ22 - High-frequency reference divided by 128 when selected
// RQ23 - Block state resets on system reset only with both enables clear
// RQ24 - Interrupt stays high while any masked event is pending
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module rtcpc_top
  import rtcpc_pkg::*;
#(
  parameter int MEM_WORDS = 64
) (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_CE,
  input wire logic I_COLD_POR,
  input wire logic I_REF_TICK,
  input wire logic I_LOW_BATTERY,
  input wire logic I_RESUME_PIN_N,
  input wire logic [ADDR_W-1:0] I_AXI_AWADDR,
  input wire logic I_AXI_AWVALID,
  output logic O_AXI_AWREADY,
  input wire logic [DATA_W-1:0] I_AXI_WDATA,
  input wire logic [3:0] I_AXI_WSTRB,
  input wire logic I_AXI_WVALID,
  output logic O_AXI_WREADY,
  output logic [1:0] O_AXI_BRESP,
  output logic O_AXI_BVALID,
  input wire logic I_AXI_BREADY,
  input wire logic [ADDR_W-1:0] I_AXI_ARADDR,
  input wire logic I_AXI_ARVALID,
  output logic O_AXI_ARREADY,
  output logic [DATA_W-1:0] O_AXI_RDATA,
  output logic [1:0] O_AXI_RRESP,
  output logic O_AXI_RVALID,
  input wire logic I_AXI_RREADY,
  output logic O_REGULATOR_ENABLE_N_O,
  output logic O_REGULATOR_ENABLE_N_OE,
  output logic O_IRQ
);

  // Byte-lane merge of a write into an old word
  function automatic logic [DATA_W-1:0] wmerge(input logic [DATA_W-1:0] old_v,
                                               input logic [DATA_W-1:0] new_v,
                                               input logic [3:0] strb);
    logic [DATA_W-1:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : wmerge

  // Bus-side state
  logic aw_ok_reg, w_ok_reg, bvalid_reg, rvalid_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [DATA_W-1:0] w_data_reg, rdata_reg;
  logic [3:0] w_strb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  // Block-side state
  rtcpc_ctl_type ctl_reg;
  rtcpc_pwr_type pwr_reg;
  logic [DATA_W-1:0] count_reg, match0_reg, match1_reg, load_reg;
  logic [EV_W-1:0] mask_reg, raw_reg;
  logic [TRIM_W-1:0] trim_reg, pre_reg;
  logic [HF_DIV_W-1:0] hf_reg;
  logic [SEC_IDX_W-1:0] sec_idx_reg;
  logic eq0_d_reg, eq1_d_reg;
  logic [DATA_W-1:0] mem_reg [MEM_WORDS];

  // Block reset ignores a system reset while counting or pin resume is enabled
  wire blk_rst = I_COLD_POR | (I_SYS_RST & ~ctl_reg.counter_enable & ~ctl_reg.pin_resume_enable); // [RQ23]

  // Write channel handshakes and decode of the held address
  assign O_AXI_AWREADY = ~aw_ok_reg & ~bvalid_reg;
  assign O_AXI_WREADY = ~w_ok_reg & ~bvalid_reg;
  wire do_wr = aw_ok_reg & w_ok_reg & ~bvalid_reg;
  wire wr_match0 = do_wr & (aw_addr_reg == OFS_MATCH0);
  wire wr_match1 = do_wr & (aw_addr_reg == OFS_MATCH1);
  wire wr_load = do_wr & (aw_addr_reg == OFS_LOAD);
  wire wr_ctrl = do_wr & (aw_addr_reg == OFS_CTRL);
  wire wr_mask = do_wr & (aw_addr_reg == OFS_MASK);
  wire wr_clear = do_wr & (aw_addr_reg == OFS_CLEAR);
  wire wr_trim = do_wr & (aw_addr_reg == OFS_TRIM);
  wire wr_mem_hit = (aw_addr_reg >= OFS_MEM_LO) & (aw_addr_reg <= OFS_MEM_HI);
  wire wr_mem = do_wr & wr_mem_hit;
  wire wr_ro = (aw_addr_reg == OFS_COUNT) | (aw_addr_reg == OFS_RAW) | (aw_addr_reg == OFS_MSKD);
  wire wr_known = (aw_addr_reg[1:0] == 2'b00) & (wr_ro | wr_mem_hit | (aw_addr_reg >= OFS_MATCH0
                  & aw_addr_reg <= OFS_MASK) | (aw_addr_reg == OFS_CLEAR) | (aw_addr_reg == OFS_TRIM));
  wire [ADDR_W-1:0] wr_mem_off = aw_addr_reg - OFS_MEM_LO;
  wire [MEM_IDX_W-1:0] wr_idx = wr_mem_off[MEM_IDX_W+1:2];
  wire [DATA_W-1:0] ctl_word = {24'h000000, ctl_reg.abort_on_low_battery, ctl_reg.clk_en,
                               ctl_reg.low_battery_detect_en, ctl_reg.pin_resume_enable,
                               ctl_reg.match_resume_enable, ctl_reg.clk_sel, 1'b0, ctl_reg.counter_enable};
  wire [DATA_W-1:0] ctl_new = wmerge(ctl_word, w_data_reg, w_strb_reg);
  wire sleep_req = wr_ctrl & ctl_new[CTL_SLEEP_REQ]; // [RQ13]
  wire [DATA_W-1:0] clr_word = w_data_reg & wmerge(32'h00000000, 32'hffffffff, w_strb_reg);

  // Bus write address and data capture in either order, response after both
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      aw_ok_reg <= 1'b0;
      w_ok_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (I_CE) begin
      if (I_AXI_AWVALID & O_AXI_AWREADY) begin
        aw_ok_reg <= 1'b1;
        aw_addr_reg <= I_AXI_AWADDR;
      end
      if (I_AXI_WVALID & O_AXI_WREADY) begin
        w_ok_reg <= 1'b1;
        w_data_reg <= I_AXI_WDATA;
        w_strb_reg <= I_AXI_WSTRB;
      end
      if (do_wr) begin
        aw_ok_reg <= 1'b0;
        w_ok_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (I_AXI_BREADY) begin
        bvalid_reg <= 1'b0;
      end
    end
  end
  assign O_AXI_BVALID = bvalid_reg;
  assign O_AXI_BRESP = bresp_reg;

  // Read decode and data selection
  assign O_AXI_ARREADY = ~rvalid_reg;
  wire rd_mem_hit = (I_AXI_ARADDR >= OFS_MEM_LO) & (I_AXI_ARADDR <= OFS_MEM_HI);
  wire [ADDR_W-1:0] rd_mem_off = I_AXI_ARADDR - OFS_MEM_LO;
  wire [MEM_IDX_W-1:0] rd_idx = rd_mem_off[MEM_IDX_W+1:2];
  wire [EV_W-1:0] mskd = raw_reg & mask_reg; // [RQ19]
  wire rd_aligned = I_AXI_ARADDR[1:0] == 2'b00;
  wire rd_reg_hit = I_AXI_ARADDR <= OFS_TRIM;
  wire rd_known = rd_aligned & (rd_mem_hit | rd_reg_hit);
  wire [DATA_W-1:0] rd_word =
    rd_mem_hit ? mem_reg[rd_idx] : // [RQ11]
    (I_AXI_ARADDR == OFS_COUNT) ? count_reg :
    (I_AXI_ARADDR == OFS_MATCH0) ? match0_reg :
    (I_AXI_ARADDR == OFS_MATCH1) ? match1_reg :
    (I_AXI_ARADDR == OFS_LOAD) ? load_reg :
    (I_AXI_ARADDR == OFS_CTRL) ? (ctl_word | (32'h00000001 << CTL_DONE)) :
    (I_AXI_ARADDR == OFS_MASK) ? {28'h0000000, mask_reg} :
    (I_AXI_ARADDR == OFS_RAW) ? {28'h0000000, raw_reg} : // [RQ19]
    (I_AXI_ARADDR == OFS_MSKD) ? {28'h0000000, mskd} :
    (I_AXI_ARADDR == OFS_TRIM) ? {16'h0000, trim_reg} : 32'h00000000;

  // Read response register
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (I_CE) begin
      if (I_AXI_ARVALID & O_AXI_ARREADY) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_known ? rd_word : 32'h00000000;
        rresp_reg <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end else if (I_AXI_RREADY) begin
        rvalid_reg <= 1'b0;
      end
    end
  end
  assign O_AXI_RVALID = rvalid_reg;
  assign O_AXI_RDATA = rdata_reg;
  assign O_AXI_RRESP = rresp_reg;

  // Reference tick: direct 32.768 kHz, or high-frequency input divided by 128
  wire hf_wrap = hf_reg == HF_DIV_LAST;
  wire tick32 = ctl_reg.clk_en & I_REF_TICK & (ctl_reg.clk_sel | hf_wrap); // [RQ22]
  wire pre_zero = pre_reg == '0;
  wire sec_pulse = tick32 & ctl_reg.counter_enable & pre_zero; // [RQ5] [RQ9]
  wire trim_second = sec_idx_reg == SEC_IDX_LAST;
  wire [TRIM_W-1:0] reload = trim_second ? trim_reg : TRIM_NOMINAL; // [RQ6] [RQ7]

  // Predivider and trim-second index
  always_ff @(posedge I_CLK) begin
    if (blk_rst) begin
      hf_reg <= '0;
      pre_reg <= TRIM_NOMINAL;
      sec_idx_reg <= '0;
    end else if (I_CE) begin
      if (ctl_reg.clk_en & ~ctl_reg.clk_sel & I_REF_TICK) begin
        hf_reg <= hf_reg + 7'h01; // [RQ22]
      end
      if (tick32 & ctl_reg.counter_enable) begin
        pre_reg <= pre_zero ? reload : pre_reg - 16'h0001; // [RQ5] [RQ6]
      end
      if (sec_pulse) begin
        sec_idx_reg <= sec_idx_reg + 6'h01;
      end
    end
  end

  // Seconds counter: a load write wins over the once-per-second step
  always_ff @(posedge I_CLK) begin
    if (blk_rst) begin
      count_reg <= RST_COUNT;
    end else if (I_CE) begin
      if (wr_load) begin
        count_reg <= wmerge(count_reg, w_data_reg, w_strb_reg); // [RQ10]
      end else if (sec_pulse) begin
        count_reg <= count_reg + 32'h00000001; // [RQ4]
      end
    end
  end

  // Match comparators and event sources
  wire eq0 = count_reg == match0_reg; // [RQ8]
  wire eq1 = count_reg == match1_reg; // [RQ8]
  wire pin_on = ~I_RESUME_PIN_N;
  wire batt_low = ctl_reg.low_battery_detect_en & I_LOW_BATTERY & (pwr_reg == PWR_ON); // [RQ1] [RQ3]
  wire [EV_W-1:0] ev_set = {pin_on, batt_low, eq1 & ~eq1_d_reg, eq0 & ~eq0_d_reg}; // [RQ17]
  wire [EV_W-1:0] ev_clr = wr_clear ? clr_word[EV_W-1:0] : '0;
  wire abort_sleep = batt_low & ctl_reg.abort_on_low_battery; // [RQ2]
  wire go_sleep = sleep_req & (pwr_reg == PWR_ON) & ~abort_sleep; // [RQ2] [RQ13]
  wire resume = (ctl_reg.pin_resume_enable & pin_on) | (ctl_reg.match_resume_enable & (eq0 | eq1)); // [RQ15]

  // Configuration registers, match values and event flags
  always_ff @(posedge I_CLK) begin
    if (blk_rst) begin
      ctl_reg <= '0;
      match0_reg <= RST_MATCH;
      match1_reg <= RST_MATCH;
      load_reg <= RST_LOAD;
      mask_reg <= '0;
      raw_reg <= '0;
      trim_reg <= TRIM_NOMINAL;
      eq0_d_reg <= 1'b0;
      eq1_d_reg <= 1'b0;
    end else if (I_CE) begin
      if (wr_ctrl) begin
        ctl_reg <= {ctl_new[CTL_ABORT], ctl_new[CTL_CLK_EN], ctl_new[CTL_LBAT_EN], ctl_new[CTL_PIN_RES],
                    ctl_new[CTL_MATCH_RES], ctl_new[CTL_CLK_SEL], ctl_new[CTL_CNT_EN]};
      end
      if (wr_match0) begin
        match0_reg <= wmerge(match0_reg, w_data_reg, w_strb_reg);
      end
      if (wr_match1) begin
        match1_reg <= wmerge(match1_reg, w_data_reg, w_strb_reg);
      end
      if (wr_load) begin
        load_reg <= wmerge(load_reg, w_data_reg, w_strb_reg);
      end
      if (wr_mask) begin
        mask_reg <= w_strb_reg[0] ? w_data_reg[EV_W-1:0] : mask_reg;
      end
      if (wr_trim) begin
        trim_reg <= {w_strb_reg[1] ? w_data_reg[15:8] : trim_reg[15:8],
                     w_strb_reg[0] ? w_data_reg[7:0] : trim_reg[7:0]};
      end
      raw_reg <= (raw_reg & ~ev_clr) | ev_set; // [RQ21] [RQ16]
      eq0_d_reg <= eq0;
      eq1_d_reg <= eq1;
    end
  end

  // Retained memory words, kept through sleep and never reset
  always_ff @(posedge I_CLK) begin
    if (I_CE & wr_mem) begin
      mem_reg[wr_idx] <= wmerge(mem_reg[wr_idx], w_data_reg, w_strb_reg); // [RQ11]
    end
  end

  // Power state: sleep on request, wake on an enabled resume source
  always_ff @(posedge I_CLK) begin
    if (blk_rst) begin
      pwr_reg <= PWR_ON;
    end else if (I_CE) begin
      unique case (pwr_reg)
        PWR_ON: begin
          if (go_sleep) begin
            pwr_reg <= PWR_SLEEP; // [RQ12]
          end
        end
        PWR_SLEEP: begin
          if (resume) begin
            pwr_reg <= PWR_ON; // [RQ12] [RQ15]
          end
        end
      endcase
    end
  end

  // Open-drain regulator enable pulls low while asleep
  assign O_REGULATOR_ENABLE_N_O = 1'b0;
  assign O_REGULATOR_ENABLE_N_OE = pwr_reg == PWR_SLEEP; // [RQ12]
  assign O_IRQ = |mskd; // [RQ18] [RQ20] [RQ24]

  // Checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST || I_COLD_POR);

  a_low_battery_flag_flag_set: assert property (I_CE && batt_low |=> raw_reg[EV_LOW_BATTERY_FLAG]) // [RQ1]
    else $error("low battery not flagged");
  a_abort_blocks_sleep: assert property (I_CE && sleep_req && abort_sleep && pwr_reg == PWR_ON
    |=> pwr_reg == PWR_ON && !O_REGULATOR_ENABLE_N_OE) // [RQ2]
    else $error("sleep not refused on low battery");
  a_sleep_no_battery: assert property (pwr_reg == PWR_SLEEP && !raw_reg[EV_LOW_BATTERY_FLAG]
    |=> !raw_reg[EV_LOW_BATTERY_FLAG]) // [RQ3]
    else $error("battery sensed while asleep");
  a_count_step: assert property (I_CE && sec_pulse && !wr_load |=> count_reg == $past(count_reg) + 1) // [RQ4]
    else $error("counter did not step");
  a_trim_second_load: assert property (I_CE && sec_pulse && trim_second |=> pre_reg == $past(trim_reg)) // [RQ6]
    else $error("trim not used in trim second");
  a_count_hold_off: assert property (I_CE && !ctl_reg.counter_enable && !wr_load
    |=> $stable(count_reg)) // [RQ9]
    else $error("counter moved while disabled");
  a_load_replace: assert property (I_CE && wr_load && w_strb_reg == 4'hf
    |=> count_reg == $past(w_data_reg)) // [RQ10]
    else $error("load write did not replace counter");
  a_sleep_enter: assert property (I_CE && go_sleep |=> O_REGULATOR_ENABLE_N_OE ##1 1) // [RQ12]
    else $error("regulator not switched off");
  a_pin_resume: assert property (I_CE && pwr_reg == PWR_SLEEP && ctl_reg.pin_resume_enable && pin_on
    |=> !O_REGULATOR_ENABLE_N_OE && raw_reg[EV_WAKE]) // [RQ15]
    else $error("pin resume failed");
  a_irq_masked: assert property (O_IRQ == |(raw_reg & mask_reg)) // [RQ20]
    else $error("interrupt disagrees with masked status");
  a_clear_one: assert property (I_CE && wr_clear && clr_word[EV_MATCH0] && !ev_set[EV_MATCH0]
    |=> !raw_reg[EV_MATCH0]) // [RQ21]
    else $error("event not cleared");
  // Event flags, resume by match, reload counts and divider checks
  a_match_event: assert property (I_CE && eq0 && !eq0_d_reg |=> raw_reg[EV_MATCH0]) // [RQ8] [RQ17]
    else $error("match event not flagged");
  a_wake_flag: assert property (I_CE && pin_on |=> raw_reg[EV_WAKE]) // [RQ17]
    else $error("wake pin not flagged");
  a_wake_kept: assert property (I_CE && raw_reg[EV_WAKE] && !(wr_clear && clr_word[EV_WAKE]) // [RQ16]
    |=> raw_reg[EV_WAKE])
    else $error("wake cause lost");
  a_match_resume: assert property (I_CE && pwr_reg == PWR_SLEEP && ctl_reg.match_resume_enable // [RQ15]
    && (eq0 || eq1) |=> !O_REGULATOR_ENABLE_N_OE)
    else $error("match resume failed");
  a_plain_reload: assert property (I_CE && sec_pulse && !trim_second |=> pre_reg == TRIM_NOMINAL) // [RQ6]
    else $error("nominal count not reloaded");
  a_sleep_on_request: assert property (I_CE && pwr_reg == PWR_ON && !sleep_req |=> pwr_reg == PWR_ON) // [RQ13]
    else $error("sleep without request");
  a_hf_divide: assert property (I_CE && !ctl_reg.clk_sel && I_REF_TICK && !hf_wrap |-> !tick32) // [RQ22]
    else $error("reference tick not divided");
  a_low_battery_flag_irq: assert property (raw_reg[EV_LOW_BATTERY_FLAG] && mask_reg[EV_LOW_BATTERY_FLAG] |-> O_IRQ) // [RQ24]
    else $error("masked low battery without interrupt");
  c_sleep_resume: cover property (go_sleep ##[1:50] (pwr_reg == PWR_ON));
  c_load_write: cover property (wr_load);
  c_irq_raised: cover property ($rose(O_IRQ));
  c_mem_write: cover property (wr_mem);
  c_match_resume: cover property (pwr_reg == PWR_SLEEP && ctl_reg.match_resume_enable && (eq0 || eq1));
endmodule : rtcpc_top

// ### bench/rtcpc_supply_model.sv
// External regulator and wake button model facing the power-control pins
`timescale 1ns/1ps
module rtcpc_supply_model (
  input wire logic i_clk,
  input wire logic i_enable_n_o,
  input wire logic i_enable_n_oe,
  input wire logic i_wake,
  input wire logic [3:0] i_hold,
  output logic o_resume_pin_n,
  output logic o_supply_on
);
  logic pressed_reg = 1'b0;
  logic [3:0] left_reg = 4'h0;

  // Pull-up on the open-drain enable: a released pin reads high and the regulator runs
  assign o_supply_on = i_enable_n_oe ? i_enable_n_o : 1'b1;
  // Wake pin has a weak pull-up, so the button can only pull it low
  assign o_resume_pin_n = ~pressed_reg;

  // Button stays pressed for a bench-chosen number of cycles, short or long
  always @(posedge i_clk) begin
    if (i_wake) begin
      pressed_reg <= 1'b1;
      left_reg <= i_hold;
    end else if (left_reg != 4'h0) begin
      left_reg <= left_reg - 4'h1;
    end else begin
      pressed_reg <= 1'b0;
    end
  end
endmodule : rtcpc_supply_model

// ### bench/testbench.sv
// Self-checking bench: bus master, power-control scenarios and response scoreboard
`timescale 1ns/1ps
module testbench;
  import rtcpc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, por = 1'b1, tick = 1'b0, low_battery_flag = 1'b0, wake = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata, lv, v;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, oe, reg_o, irq, pin_n, supply_on;
  logic [1:0] bresp, rresp;
  logic [3:0] hold = 4'h3;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [31:0] mem[64];
  int n_errors = 0;
  int n_compared = 0;
  int n;

  rtcpc_top #(.MEM_WORDS(64)) uut (
    .I_CLK(clk), .I_SYS_RST(rst), .I_CE(1'b1), .I_COLD_POR(por), .I_REF_TICK(tick),
    .I_LOW_BATTERY(low_battery_flag), .I_RESUME_PIN_N(pin_n), .I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awvalid),
    .O_AXI_AWREADY(awready), .I_AXI_WDATA(wdata), .I_AXI_WSTRB(4'hf), .I_AXI_WVALID(wvalid),
    .O_AXI_WREADY(wready), .O_AXI_BRESP(bresp), .O_AXI_BVALID(bvalid), .I_AXI_BREADY(bready),
    .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid), .O_AXI_ARREADY(arready), .O_AXI_RDATA(rdata),
    .O_AXI_RRESP(rresp), .O_AXI_RVALID(rvalid), .I_AXI_RREADY(rready),
    .O_REGULATOR_ENABLE_N_O(reg_o), .O_REGULATOR_ENABLE_N_OE(oe), .O_IRQ(irq));

  rtcpc_supply_model model (.i_clk(clk), .i_enable_n_o(reg_o), .i_enable_n_oe(oe), .i_wake(wake),
    .i_hold(hold), .o_resume_pin_n(pin_n), .o_supply_on(supply_on));

  // Free-running 25 MHz clock
  initial begin
    forever #20 clk = ~clk;
  end

  task automatic finish_test();
    if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  task automatic cmp_rd(input logic [33:0] e, input logic [33:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected read at %0t: expected %h got %h", $time, e, g);
    end
  endtask : cmp_rd

  task automatic cmp_resp(input logic [1:0] e, input logic [1:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected write response at %0t: expected %h got %h", $time, e, g);
    end
  endtask : cmp_resp

  task automatic cmp_pin(input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected pin level at %0t: expected %h got %h", $time, e, g);
    end
  endtask : cmp_pin

  // A wait that runs out of cycles ends the run as a failure
  task automatic bail();
    n_errors++;
    finish_test();
  endtask : bail

  // Write with address and data offered together, each released when taken
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] r = RESP_OKAY);
    logic aw_done, w_done;
    int k;
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_done = 1'b0;
    w_done = 1'b0;
    for (k = 0; k < 50 && !(aw_done && w_done); k++) begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      aw_done = aw_done | (awready === 1'b1);
      w_done = w_done | (wready === 1'b1);
    end
    for (k = 0; k < 50 && bvalid !== 1'b1; k++) @(posedge clk);
    if (bvalid !== 1'b1) bail();
    bready <= 1'b0;
    @(posedge clk);
  endtask : wr

  // Read: address held until taken, rready held until data is seen
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] r = RESP_OKAY);
    int k;
    rq.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (arready !== 1'b1 && k < 50);
    if (arready !== 1'b1) bail();
    arvalid <= 1'b0;
    for (k = 0; k < 50 && rvalid !== 1'b1; k++) @(posedge clk);
    if (rvalid !== 1'b1) bail();
    rready <= 1'b0;
    @(posedge clk);
  endtask : rd

  task automatic wait_oe(input logic e);
    int k;
    for (k = 0; k < 20 && oe !== e; k++) @(posedge clk);
    cmp_pin(e, oe);
  endtask : wait_oe

  task automatic sys_reset();
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask : sys_reset

  // Scoreboard: each bus answer is matched against the oldest expectation
  always @(posedge clk) begin
    if (rvalid && rready) cmp_rd(rq.size() ? rq.pop_front() : '1, {rresp, rdata});
    if (bvalid && bready) cmp_resp(bq.size() ? bq.pop_front() : 2'b11, bresp);
  end

  // Main sequence
  initial begin
    void'($urandom(32'h384adbf4));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    @(posedge clk);
    // Reset values, read-only and unmapped places
    rd(OFS_MATCH0, 32'hffffffff);
    rd(OFS_MATCH1, 32'hffffffff);
    rd(OFS_LOAD, 32'hffffffff);
    rd(OFS_CTRL, 32'h80000000);
    rd(OFS_MASK, 32'h0);
    rd(OFS_MSKD, 32'h0);
    rd(OFS_CLEAR, 32'h0);
    rd(OFS_TRIM, 32'h7fff);
    wr(OFS_COUNT, 32'h5a5a5a5a);
    rd(OFS_COUNT, 32'h0);
    wr(12'h028, 32'h1, RESP_SLVERR);
    rd(12'h028, 32'h0, RESP_SLVERR);
    rd(12'h031, 32'h0, RESP_SLVERR);
    v = $urandom;
    wr(OFS_TRIM, {16'h0, v[15:0]});
    rd(OFS_TRIM, {16'h0, v[15:0]});
    wr(OFS_TRIM, 32'h7fff);
    // Retained memory, every word
    for (int i = 0; i < 64; i++) begin
      mem[i] = $urandom;
      wr(OFS_MEM_LO + ADDR_W'(4 * i), mem[i]);
    end
    for (int i = 0; i < 64; i++) rd(OFS_MEM_LO + ADDR_W'(4 * i), mem[i]);
    // One second of reference ticks reaches match 0 and raises the interrupt
    lv = $urandom & 32'h7fffffff;
    wr(OFS_MATCH0, lv + 32'h1);
    wr(OFS_LOAD, lv);
    rd(OFS_COUNT, lv);
    wr(OFS_MASK, 32'h1);
    wr(OFS_CLEAR, 32'hf);
    wr(OFS_CTRL, 32'h45);
    tick <= 1'b1;
    for (n = 0; n < 33000 && irq !== 1'b1; n++) @(posedge clk);
    cmp_pin(1'b1, irq);
    cmp_pin(1'b1, n > 32700);
    rd(OFS_COUNT, lv + 32'h1);
    rd(OFS_MSKD, 32'h1);
    wr(OFS_CLEAR, 32'h2);
    rd(OFS_RAW, 32'h1);
    cmp_pin(1'b1, irq);
    wr(OFS_CLEAR, 32'h1);
    cmp_pin(1'b0, irq);
    // A disabled counter holds through a full second of ticks
    wr(OFS_CTRL, 32'h44);
    repeat (33000) @(posedge clk);
    rd(OFS_COUNT, lv + 32'h1);
    tick <= 1'b0;
    // Match 1 reached through a load, first masked out
    wr(OFS_MATCH1, lv + 32'h64);
    wr(OFS_LOAD, lv + 32'h64);
    rd(OFS_RAW, 32'h2);
    rd(OFS_MSKD, 32'h0);
    cmp_pin(1'b0, irq);
    wr(OFS_MASK, 32'h2);
    cmp_pin(1'b1, irq);
    wr(OFS_CLEAR, 32'h2);
    // Low battery flags and blocks a sleep request
    low_battery_flag <= 1'b1;
    wr(OFS_CTRL, 32'hf4);
    rd(OFS_RAW, 32'h4);
    rd(OFS_CTRL, 32'h800000f4);
    wr(OFS_CTRL, 32'hf6);
    cmp_pin(1'b0, oe);
    low_battery_flag <= 1'b0;
    wr(OFS_CLEAR, 32'hf);
    rd(OFS_RAW, 32'h0);
    // Sleep, battery ignored meanwhile, then the wake pin resumes
    wr(OFS_CTRL, 32'hf6);
    wait_oe(1'b1);
    cmp_pin(1'b0, supply_on);
    low_battery_flag <= 1'b1;
    repeat (4) @(posedge clk);
    rd(OFS_RAW, 32'h0);
    low_battery_flag <= 1'b0;
    hold <= 4'($urandom_range(1, 9));
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    wait_oe(1'b0);
    cmp_pin(1'b1, supply_on);
    rd(OFS_RAW, 32'h8);
    repeat (12) @(posedge clk);
    wr(OFS_CLEAR, 32'hf);
    // Sleep with match resume only, woken by a load onto match 0
    wr(OFS_MATCH0, lv + 32'hc8);
    wr(OFS_MATCH1, lv + 32'h12c);
    wr(OFS_CTRL, 32'h4a);
    wait_oe(1'b1);
    wr(OFS_LOAD, lv + 32'hc8);
    wait_oe(1'b0);
    rd(OFS_RAW, 32'h1);
    // System reset keeps the block while counting, resets it once both enables are clear
    v = $urandom;
    wr(OFS_CTRL, 32'h41);
    wr(OFS_MATCH1, v);
    sys_reset();
    rd(OFS_MATCH1, v);
    wr(OFS_CTRL, 32'h40);
    sys_reset();
    rd(OFS_MATCH1, 32'hffffffff);
    rd(OFS_CTRL, 32'h80000000);
    finish_test();
  end
endmodule : testbench
